// ===== dic_pkg.sv
// package: constants and types for the dsp interrupt and low power control
package dic_pkg;
  // ---------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_MASK = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h1;
  localparam logic [3:0] ADDR_FORCE = 4'h2;
  localparam logic [3:0] ADDR_PEND = 4'h3;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h5;
  localparam logic [3:0] ADDR_ABCTL0 = 4'h6;
  localparam logic [15:0] ADDR_ABCTL0_DM = 16'h3FF3;
  // ---------------------------------------------------------------
  // sources, index 0 = highest maskable priority
  // ---------------------------------------------------------------
  localparam int NSRC = 10;
  localparam int SRC_EXT2 = 0;
  localparam int SRC_SW1 = 5;
  localparam int SRC_SW0 = 6;
  localparam int SRC_SP1T = 7;
  localparam int SRC_SP1R = 8;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWD = 14'h002C;
  localparam logic [13:0] VEC_BASE = 14'h0004;
  localparam logic [13:0] VEC_STEP = 14'h0004;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_EDGE0 = 0;
  localparam int CTRL_EDGE2 = 2;
  localparam int CTRL_NEST = 4;
  localparam int CTRL_SP1CFG = 5;
  localparam int CTRL_XTALOFF = 6;
  localparam int CTRL_POWERUP_CONTEXT_RESET_BIT = 7;
  localparam int ABCTL_CLOCK_OUTPUT_DISABLE_BIT = 14;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // command codes
  localparam logic [3:0] CMD_ENA = 4'h1;
  localparam logic [3:0] CMD_DIS = 4'h2;
  localparam logic [3:0] CMD_IDLE = 4'h3;
  localparam logic [3:0] CMD_RTI = 4'h4;
  localparam logic [3:0] CMD_PWDN = 4'h5;
  localparam logic [3:0] CMD_PWDF = 4'h6;
  // ---------------------------------------------------------------
  // timing: input clock is half the 10 MHz processor clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int INPUT_CLOCK_PIN_PER_CYC = 2;
  localparam int WAKE_INPUT_CLOCK_PIN = 100;
  localparam int XTAL_INPUT_CLOCK_PIN = 4096;
  localparam int WAKE_CYC = WAKE_INPUT_CLOCK_PIN * INPUT_CLOCK_PIN_PER_CYC;
  localparam int XTAL_CYC = XTAL_INPUT_CLOCK_PIN * INPUT_CLOCK_PIN_PER_CYC;
  localparam int STACK_DEPTH = 12;
  localparam int DIV_W = 8;
  // one-hot states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_IDLE = 4'h2,
    ST_PWDN = 4'h4,
    ST_WAKE = 4'h8
  } dic_state_t;
  // vector handed to the sequencer
  typedef struct packed {
    logic valid;
    logic [13:0] addr;
  } dic_vec_t;
endpackage

// ===== dic_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dic_sync
  import dic_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  // a change counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// ===== dic_ctrl.sv
// interrupt priority, masking, vectoring and low power control
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module dic_ctrl
  import dic_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC,
  parameter int XTAL_CYCLES = XTAL_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic ext_int_req_0_n,
  input wire logic ext_int_req_1_n,
  input wire logic ext_int_req_2_n,
  input wire logic powerdown_request_pin_n,
  input wire logic hostSoftReset,
  input wire logic [3:0] periphReq,
  input wire logic timerReq,
  input wire logic [15:0] statusIn,
  output logic [15:0] statusOut,
  output logic vecValid,
  output logic [13:0] vecAddr,
  input wire logic vecTaken,
  output logic coreRun,
  output logic contextClear,
  output logic slowTick,
  output logic processor_clock_output,
  output logic powerdown_ack_pin
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pinRaw;
  logic [3:0] pinSync;
  assign pinRaw = {powerdown_request_pin_n, ext_int_req_2_n,
                   ext_int_req_1_n, ext_int_req_0_n};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      dic_sync #(.INIT(1'b1)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(pinRaw[gi]),
        .dout(pinSync[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // registers and register port
  // ---------------------------------------------------------------
  logic [15:0] interrupt_mask_reg;
  logic [15:0] interrupt_control_reg;
  logic [15:0] abCtl0;
  logic globalEn;
  logic maskBlock;
  logic [NSRC-1:0] pend;
  logic [3:0] pinPrev;
  logic pwdPend;
  dic_state_t state;
  dic_state_t next_state;
  logic [DIV_W-1:0] divSel;
  logic [DIV_W-1:0] divCnt;
  logic [13:0] wakeCnt;
  logic [3:0] sp;
  logic [15:0] stack [STACK_DEPTH];
  logic [NSRC:0] activeLvl;

  wire wrMask = regWr && regAddr == ADDR_MASK;
  wire wrCtrl = regWr && regAddr == ADDR_CTRL;
  wire wrForce = regWr && regAddr == ADDR_FORCE;
  wire wrCmd = regWr && regAddr == ADDR_CMD;
  wire wrAb = regWr && regAddr == ADDR_ABCTL0;
  wire [3:0] cmd = regWdata[3:0];
  wire sp1Irq = interrupt_control_reg[CTRL_SP1CFG];

  // decode of the read mux; force register reads as zero
  logic [15:0] rdMux;
  assign rdMux = (regAddr == ADDR_MASK) ? interrupt_mask_reg :
                 (regAddr == ADDR_CTRL) ? interrupt_control_reg :
                 (regAddr == ADDR_PEND) ? 16'(pend) :
                 (regAddr == ADDR_STAT) ?
                   {8'h00, 4'(state), globalEn, pwdPend, 2'h0} :
                 (regAddr == ADDR_ABCTL0) ? abCtl0 : 16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= rdMux;
    end
  end

  // control registers; mask cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      interrupt_mask_reg <= MASK_RST;
      interrupt_control_reg <= CTRL_RST;
      abCtl0 <= 16'h0000;
    end else begin
      if (wrMask) interrupt_mask_reg <= regWdata;
      if (wrCtrl) interrupt_control_reg <= regWdata;
      if (wrAb) abCtl0 <= regWdata;
    end
  end

  // global enable; mask write blocks one cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      globalEn <= 1'b1;
      maskBlock <= 1'b0;
    end else begin
      maskBlock <= wrMask;
      if (wrCmd && cmd == CMD_ENA) globalEn <= 1'b1;
      if (wrCmd && cmd == CMD_DIS) globalEn <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request detection
  // ---------------------------------------------------------------
  // ext0/1 live on serial port one pins only when reconfigured
  wire [2:0] extLvl = {~pinSync[2], ~pinSync[1] & sp1Irq,
                       ~pinSync[0] & sp1Irq};
  wire [2:0] extFall = {pinPrev[2] & ~pinSync[2],
                        pinPrev[1] & ~pinSync[1] & sp1Irq,
                        pinPrev[0] & ~pinSync[0] & sp1Irq};
  wire [2:0] extEdgeSel = interrupt_control_reg[CTRL_EDGE2:CTRL_EDGE0];
  wire [2:0] extLevelReq = extLvl & ~extEdgeSel;
  wire [2:0] extEdgeReq = extFall & extEdgeSel;
  wire pwdFall = pinPrev[3] & ~pinSync[3];
  // release of the pin ends powerdown; a pin held high never does
  wire pwdRise = ~pinPrev[3] & pinSync[3];

  // raw request vector by priority slot
  logic [NSRC-1:0] levelReq;
  logic [NSRC-1:0] eventReq;
  assign levelReq = {1'b0,
                     sp1Irq ? extLevelReq[0] : 1'b0,
                     sp1Irq ? extLevelReq[1] : 1'b0,
                     2'b00, 4'h0, extLevelReq[2]};
  assign eventReq = {timerReq,
                     sp1Irq ? extEdgeReq[0] : periphReq[3],
                     sp1Irq ? extEdgeReq[1] : periphReq[2],
                     4'h0, periphReq[1:0], extEdgeReq[2]};

  wire swForce = wrForce;
  wire [1:0] swSet = swForce ? regWdata[1:0] : 2'b00;
  wire [1:0] swClr = swForce ? regWdata[9:8] : 2'b00;

  // selection: mask gate, then fixed priority
  logic [NSRC-1:0] live;
  logic [NSRC-1:0] gated;
  logic [3:0] selIdx;
  logic selAny;
  assign live = pend | levelReq;
  assign gated = live & interrupt_mask_reg[NSRC-1:0];
  always_comb begin
    selIdx = 4'h0;
    selAny = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (gated[i]) begin
        selIdx = 4'(i);
        selAny = 1'b1;
      end
    end
  end

  // nesting admits only higher priority than the active level
  logic [NSRC:0] higherMask;
  // nothing outranks a running powerdown handler
  assign higherMask = (activeLvl == '0) ? {(NSRC+1){1'b1}} :
                      activeLvl[NSRC] ? '0 :
                      ((activeLvl & -activeLvl) - 1'b1);
  wire nestOk = interrupt_control_reg[CTRL_NEST] ?
                higherMask[selIdx] : (activeLvl == '0);
  // slow idle only looks at requests on its divided tick
  wire canServe = globalEn && !maskBlock && state != ST_PWDN
                  && state != ST_WAKE
                  && (state != ST_IDLE || slowTick);
  wire takePwd = canServe && pwdPend && activeLvl[NSRC] == 1'b0
                 && (interrupt_control_reg[CTRL_NEST] ||
                     activeLvl == '0);
  wire takeSrc = canServe && !takePwd && !pwdPend && selAny && nestOk;
  // a take never shares a cycle with a return, so the stack stays sane
  wire takeAny = (takePwd || takeSrc) && !vecValid
                 && sp != 4'(STACK_DEPTH) && !(wrCmd && cmd == CMD_RTI);

  // pending flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pend <= '0;
      pinPrev <= 4'hF;
      pwdPend <= 1'b0;
    end else begin
      pinPrev <= pinSync;
      // one assignment, so a set in the same cycle beats every clear
      pend <= (pend & ~((takeAny && takeSrc) ? NSRC'(1) << selIdx : '0)
               & ~(NSRC'(swClr[1]) << SRC_SW1)
               & ~(NSRC'(swClr[0]) << SRC_SW0))
              | eventReq | (NSRC'(swSet[1]) << SRC_SW1)
              | (NSRC'(swSet[0]) << SRC_SW0);
      // powerdown request is edge only and unmaskable
      if (takeAny && takePwd) pwdPend <= 1'b0;
      if (pwdFall || (wrCmd && cmd == CMD_PWDF)) pwdPend <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // vector output and status stack
  // ---------------------------------------------------------------
  wire [13:0] srcVec = VEC_BASE + 14'(selIdx) * VEC_STEP;
  wire doRti = wrCmd && cmd == CMD_RTI && sp != 4'h0;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      vecValid <= 1'b1;
      vecAddr <= VEC_RESET;
      sp <= 4'h0;
      activeLvl <= '0;
      statusOut <= 16'h0000;
    end else begin
      if (vecValid && vecTaken) vecValid <= 1'b0;
      if (takeAny) begin
        vecValid <= 1'b1;
        vecAddr <= takePwd ? VEC_PWD : srcVec;
        stack[sp] <= statusIn;
        sp <= sp + 4'h1;
        activeLvl <= activeLvl | (takePwd ? (NSRC+1)'(1) << NSRC :
                                  (NSRC+1)'(1) << selIdx);
      end else if (doRti) begin
        statusOut <= stack[sp - 4'h1];
        sp <= sp - 4'h1;
        // powerdown handler is always innermost when it is active
        activeLvl <= activeLvl[NSRC] ? {1'b0, activeLvl[NSRC-1:0]}
                                     : activeLvl & (activeLvl - 1'b1);
      end
    end
  end

  // ---------------------------------------------------------------
  // low power state machine
  // ---------------------------------------------------------------
  wire [DIV_W-1:0] reqDiv = (regWdata[7:4] == 4'h4) ? 8'h0F :
                            (regWdata[7:4] == 4'h5) ? 8'h1F :
                            (regWdata[7:4] == 4'h6) ? 8'h3F :
                            (regWdata[7:4] == 4'h7) ? 8'h7F : 8'h00;
  wire wakeDone = wakeCnt == 14'h0000;
  wire softRstEnd = hostSoftReset && !pinSync[3];
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (wrCmd && cmd == CMD_IDLE) next_state = ST_IDLE;
        if (wrCmd && cmd == CMD_PWDN && activeLvl[NSRC])
          next_state = ST_PWDN;
      end
      ST_IDLE: begin
        if ((selAny || pwdPend) && slowTick) next_state = ST_RUN;
      end
      ST_PWDN: begin
        if (pwdRise || softRstEnd) next_state = ST_WAKE;
      end
      ST_WAKE: begin
        if (wakeDone) next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= ST_RUN;
      divSel <= '0;
      divCnt <= '0;
      wakeCnt <= 14'h0000;
      coreRun <= 1'b1;
      contextClear <= 1'b0;
      powerdown_ack_pin <= 1'b0;
      slowTick <= 1'b1;
    end else begin
      state <= next_state;
      if (state == ST_RUN && wrCmd && cmd == CMD_IDLE) divSel <= reqDiv;
      divCnt <= (divCnt >= divSel) ? '0 : divCnt + 1'b1;
      slowTick <= (next_state != ST_IDLE) || (divCnt >= divSel);
      if (state == ST_PWDN && next_state == ST_WAKE)
        wakeCnt <= interrupt_control_reg[CTRL_XTALOFF] ?
                   14'(XTAL_CYCLES - 1) : 14'(WAKE_CYCLES - 1);
      else if (!wakeDone) wakeCnt <= wakeCnt - 14'h0001;
      coreRun <= next_state == ST_RUN;
      powerdown_ack_pin <= next_state == ST_PWDN;
      contextClear <= state == ST_WAKE && wakeDone
                      && interrupt_control_reg[CTRL_POWERUP_CONTEXT_RESET_BIT];
    end
  end

  // clock output: off when disabled, in powerdown, divided in slow idle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      processor_clock_output <= 1'b0;
    end else begin
      processor_clock_output <= !abCtl0[ABCTL_CLOCK_OUTPUT_DISABLE_BIT] && state != ST_PWDN
                                && slowTick && !processor_clock_output;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_mask_block: assert property (
    @(posedge clk_sys) disable iff (!resetn) wrMask |=> !takeAny)
    else $error("serviced right after mask write");
  chk_global_dis: assert property (
    @(posedge clk_sys) disable iff (!resetn) !globalEn |-> !takeAny)
    else $error("serviced while disabled");
  chk_pwd_vec: assert property (
    @(posedge clk_sys) disable iff (!resetn) takeAny && takePwd
    |=> vecValid && vecAddr == VEC_PWD) else $error("bad pwd vec");
  chk_ack_state: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    powerdown_ack_pin == (state == ST_PWDN)) else $error("ack mismatch");
  chk_mask_gate: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    takeSrc |-> interrupt_mask_reg[selIdx]) else $error("masked taken");
  chk_wake_time: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state == ST_WAKE && !interrupt_control_reg[CTRL_XTALOFF]
    |-> ##[0:200] state == ST_RUN) else $error("wake too long");
  chk_stack_depth: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    sp <= 4'(STACK_DEPTH)) else $error("stack overflow");
  chk_en_reset: assert property (
    @(posedge clk_sys) !resetn |=> globalEn)
    else $error("enable not set by reset");
  chk_prio: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    takeSrc |-> (gated & ((NSRC)'(1) << selIdx) - 1'b1) == '0)
    else $error("lower priority chosen");
  cov_pwd: cover property (@(posedge clk_sys) state == ST_PWDN);
  cov_idle: cover property (@(posedge clk_sys) state == ST_IDLE
    ##1 state == ST_RUN);
  cov_nest: cover property (@(posedge clk_sys) takeAny && activeLvl != '0);
endmodule

// ===== dic_core_model.sv
// stand-in for the program sequencer that takes vectors and feeds status
`timescale 1ns/1ps
module dic_core_model
  import dic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  input wire logic [3:0] takeDelay,
  input wire logic vecValid,
  output logic vecTaken,
  output logic [15:0] statusIn
);
  logic [3:0] waitCnt;
  // take is a single pulse; the gap after it keeps a stale valid untaken
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      vecTaken <= 1'b0;
      waitCnt <= 4'h0;
      statusIn <= 16'hA5C3;
    end else if (vecTaken) begin
      vecTaken <= 1'b0;
      waitCnt <= 4'h0;
      statusIn <= ~statusIn + 16'h0111; // new status for each handler
    end else if (vecValid && !stall) begin
      vecTaken <= (waitCnt >= takeDelay); // slow answers when delay set
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// ===== tb.sv
// self-checking bench for the interrupt and low power controller
`timescale 1ns/1ps
module tb
  import dic_pkg::*;
;
  typedef struct packed {
    logic [15:0] ctl, msk, frc;
    logic [3:0] prq;
    logic tmr;
    logic [2:0] ext;
    logic [13:0] vec;
  } dic_row_t;
  logic clk_sys, resetn, regWr, regRd, vecTaken, timerReq, hostSoftReset;
  logic stall, extN0, extN1, extN2, pwdN, vecValid, coreRun, contextClear;
  logic slowTick, processor_clock_output, powerdown_ack_pin, b;
  logic [3:0] regAddr, periphReq, takeDelay, code;
  logic [15:0] regWdata, regRdata, statusIn, statusOut, rd, s;
  logic [13:0] vecAddr;
  int nFail, checkCount, n, div;
  // rows 2 to 7 mask off the winner of the row before
  dic_row_t rows [10] = '{
    '{16'h0000, 16'h03FF, 16'h0003, 4'hF, 1'b1, 3'b100, 14'h0004},
    '{16'h0000, 16'h03FF, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h0008},
    '{16'h0000, 16'h03FD, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h000C},
    '{16'h0000, 16'h03F9, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h0018},
    '{16'h0000, 16'h03D9, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h001C},
    '{16'h0000, 16'h0399, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h0020},
    '{16'h0000, 16'h0319, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h0024},
    '{16'h0000, 16'h0219, 16'h0003, 4'hF, 1'b1, 3'b000, 14'h0028},
    '{16'h0020, 16'h03FF, 16'h0000, 4'h0, 1'b1, 3'b010, 14'h0020},
    '{16'h0020, 16'h03FF, 16'h0000, 4'h0, 1'b1, 3'b001, 14'h0024}};
  // xtal wait shortened so the run stays short
  dic_ctrl #(.XTAL_CYCLES(20)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .ext_int_req_0_n(extN0), .ext_int_req_1_n(extN1),
    .ext_int_req_2_n(extN2), .powerdown_request_pin_n(pwdN),
    .hostSoftReset(hostSoftReset), .periphReq(periphReq),
    .timerReq(timerReq), .statusIn(statusIn), .statusOut(statusOut),
    .vecValid(vecValid), .vecAddr(vecAddr), .vecTaken(vecTaken),
    .coreRun(coreRun), .contextClear(contextClear), .slowTick(slowTick),
    .processor_clock_output(processor_clock_output),
    .powerdown_ack_pin(powerdown_ack_pin));
  dic_core_model core_u (.clk_sys(clk_sys), .resetn(resetn), .stall(stall),
    .takeDelay(takeDelay), .vecValid(vecValid), .vecTaken(vecTaken),
    .statusIn(statusIn));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task testDone;
    $display("mismatches %0d, checks %0d", nFail, checkCount);
    if (nFail == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp, input string m);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH %0t %s got %b", $time, m, got);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task rdReg(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rd = regRdata; // read data hold until the next read
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return vecValid;
      1: return coreRun;
      2: return powerdown_ack_pin;
      default: return slowTick;
    endcase
  endfunction
  // bounded wait; n returns the cycles spent
  task waitFor(input int w, input logic lvl);
    n = 0;
    #1;
    while (sig(w) !== lvl) begin
      if (n > 600) begin
        nFail++;
        $display("MISMATCH %0t wait %0d timed out", $time, w);
        testDone;
      end
      cyc(1);
      n++;
    end
  endtask
  task pulse(input logic [3:0] p, input logic t);
    @(posedge clk_sys);
    periphReq <= p;
    timerReq <= t;
    @(posedge clk_sys);
    periphReq <= 4'h0;
    timerReq <= 1'b0;
  endtask
  task chkVec(input logic [13:0] v);
    chk({2'b00, vecAddr}, {2'b00, v}, "vector");
  endtask
  task takeRti;
    s = statusIn;
    stall <= 1'b0;
    waitFor(0, 1'b0);
    stall <= 1'b1;
    wr(ADDR_CMD, {12'h000, CMD_RTI});
    cyc(2);
    chk(statusOut, s, "popped status");
  endtask
  // clears leftovers: unmask all and let the core take and return
  task drain;
    wr(ADDR_FORCE, 16'h0300);
    wr(ADDR_MASK, 16'h03FF);
    stall <= 1'b0;
    repeat (11) begin
      cyc(8);
      wr(ADDR_CMD, {12'h000, CMD_RTI});
    end
    stall <= 1'b1;
    cyc(4);
  endtask
  task pwdEnter(input logic sw);
    wr(ADDR_MASK, 16'h0000);
    if (sw) wr(ADDR_CMD, {12'h000, CMD_PWDF});
    else begin
      @(posedge clk_sys);
      pwdN <= 1'b0;
    end
    waitFor(0, 1'b1);
    chkVec(VEC_PWD);
    // handler keeps running and chooses to power down
    stall <= 1'b0;
    waitFor(0, 1'b0);
    stall <= 1'b1;
    rdReg(ADDR_STAT);
    chkb(rd[2], 1'b0, "powerdown request consumed");
    wr(ADDR_CMD, {12'h000, CMD_PWDN});
    waitFor(2, 1'b1);
    chkb(coreRun, 1'b0, "halted in powerdown");
  endtask
  // -------------------------------------------------------------
  // clock and sequence
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {resetn, regWr, regRd, timerReq, hostSoftReset} = 5'b00000;
    {stall, extN0, extN1, extN2, pwdN} = 5'b11111;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    periphReq = 4'h0;
    takeDelay = 4'h0;
    nFail = 0;
    checkCount = 0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(1);
    chkb(vecValid, 1'b1, "reset vector valid");
    chkVec(VEC_RESET);
    chkb(coreRun & ~powerdown_ack_pin, 1'b1, "running after reset");
    rdReg(ADDR_MASK);
    chk(rd, MASK_RST, "mask reset");
    rdReg(ADDR_CTRL);
    chk(rd, CTRL_RST, "control reset");
    rdReg(ADDR_STAT);
    chkb(rd[3], 1'b1, "global enable at reset");
    drain;
    // table of priority and masking cases
    foreach (rows[i]) begin
      takeDelay <= 4'(i % 4);
      wr(ADDR_CTRL, rows[i].ctl);
      wr(ADDR_MASK, 16'h0000);
      wr(ADDR_FORCE, rows[i].frc);
      @(posedge clk_sys);
      {extN2, extN1, extN0} <= ~rows[i].ext;
      pulse(rows[i].prq, rows[i].tmr);
      cyc(4);
      wr(ADDR_MASK, rows[i].msk);
      waitFor(0, 1'b1);
      chkVec(rows[i].vec);
      @(posedge clk_sys);
      {extN2, extN1, extN0} <= 3'b111;
      takeRti;
      drain;
    end
    wr(ADDR_CTRL, 16'h0000);
    // mask write holds off a ready request for one cycle
    wr(ADDR_MASK, 16'h0000);
    pulse(4'h0, 1'b1);
    cyc(4);
    wr(ADDR_MASK, 16'h0200);
    cyc(1);
    chkb(vecValid, 1'b0, "blocked after mask write");
    waitFor(0, 1'b1);
    chkVec(14'h0028);
    takeRti;
    // global disable overrides an unmasked request
    wr(ADDR_CMD, {12'h000, CMD_DIS});
    pulse(4'h0, 1'b1);
    cyc(10);
    chkb(vecValid, 1'b0, "disabled servicing");
    wr(ADDR_CMD, {12'h000, CMD_ENA});
    waitFor(0, 1'b1);
    chkVec(14'h0028);
    takeRti;
    drain;
    // edge mode: a held pin is serviced once only
    wr(ADDR_CTRL, 16'h0004);
    @(posedge clk_sys);
    extN2 <= 1'b0;
    waitFor(0, 1'b1);
    chkVec(14'h0004);
    takeRti;
    cyc(12);
    chkb(vecValid, 1'b0, "edge fires once");
    @(posedge clk_sys);
    extN2 <= 1'b1;
    wr(ADDR_CTRL, 16'h0000);
    drain;
    // nesting: a higher request preempts a running handler
    wr(ADDR_CTRL, 16'h0010);
    pulse(4'h0, 1'b1);
    waitFor(0, 1'b1);
    chkVec(14'h0028);
    stall <= 1'b0;
    waitFor(0, 1'b0);
    stall <= 1'b1;
    pulse(4'h1, 1'b0);
    waitFor(0, 1'b1);
    chkVec(14'h0008);
    takeRti;
    wr(ADDR_CTRL, 16'h0000);
    drain;
    // software force and clear, write-only register
    wr(ADDR_MASK, 16'h0000);
    wr(ADDR_FORCE, 16'h0001);
    rdReg(ADDR_PEND);
    chkb(rd[SRC_SW0], 1'b1, "software force");
    rdReg(ADDR_FORCE);
    chk(rd, 16'h0000, "force reads zero");
    wr(ADDR_FORCE, 16'h0100);
    rdReg(ADDR_PEND);
    chkb(rd[SRC_SW0], 1'b0, "software clear");
    rdReg(4'hF);
    chk(rd, 16'h0000, "unmapped read");
    drain;
    // standard idle then the four slow divisors
    for (int k = 0; k < 5; k++) begin
      code = (k == 0) ? 4'h0 : 4'(k + 3);
      div = (k == 0) ? 1 : (8 << k);
      wr(ADDR_CMD, {8'h00, code, CMD_IDLE});
      cyc(3);
      chkb(coreRun, 1'b0, "idle");
      if (k > 0) begin
        waitFor(3, 1'b1);
        cyc(1);
        waitFor(3, 1'b1);
        chkb(n + 1 == div, 1'b1, "slow tick period");
      end
      pulse(4'h0, 1'b1);
      waitFor(0, 1'b1);
      chkb(n <= div + 8, 1'b1, "idle wake latency");
      chkVec(14'h0028);
      takeRti;
      chkb(coreRun, 1'b1, "resumed after idle");
    end
    // clock output disable bit
    wr(ADDR_ABCTL0, 16'h4000);
    cyc(2);
    b = processor_clock_output;
    cyc(5);
    chkb(processor_clock_output, b, "clock output held");
    wr(ADDR_ABCTL0, 16'h0000);
    cyc(3);
    b = processor_clock_output;
    cyc(1);
    chkb(processor_clock_output, ~b, "clock output toggles");
    // powerdown by pin, left by pin with the oscillator running
    pwdEnter(1'b0);
    @(posedge clk_sys);
    pwdN <= 1'b1;
    waitFor(1, 1'b1);
    chkb(n >= WAKE_CYC - 5 && n <= WAKE_CYC + 15, 1'b1, "wake");
    chkb(powerdown_ack_pin, 1'b0, "ack dropped");
    chkb(contextClear, 1'b0, "context kept");
    drain;
    // host soft reset ends powerdown while the pin is low
    // oscillator off and context clear set for this pass
    wr(ADDR_CTRL, 16'h00C0);
    pwdEnter(1'b0);
    @(posedge clk_sys);
    hostSoftReset <= 1'b1;
    waitFor(1, 1'b1);
    chkb(powerdown_ack_pin, 1'b0, "soft reset wake");
    chkb(n >= 20 && n <= 30, 1'b1, "oscillator wait");
    chkb(contextClear, 1'b1, "context cleared");
    @(posedge clk_sys);
    hostSoftReset <= 1'b0;
    pwdN <= 1'b1;
    wr(ADDR_CTRL, 16'h0000);
    drain;
    // software powerdown ended by a reset in mid-run
    pwdEnter(1'b1);
    @(posedge clk_sys);
    hostSoftReset <= 1'b1;
    cyc(8);
    chkb(powerdown_ack_pin, 1'b1, "soft reset needs pin low");
    @(posedge clk_sys);
    hostSoftReset <= 1'b0;
    resetn <= 1'b0;
    cyc(2);
    chkb(coreRun & ~powerdown_ack_pin, 1'b1, "reset ends powerdown");
    @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(2);
    chkVec(VEC_RESET);
    testDone;
  end
endmodule
